// File: core/tisdc_top.v
// Timer input select, count sources and double-register capture with APB register access
// Operation
// - Aux two-bit select picks one of four
// - Bit 7 selects aux upper input group
// - Bit 6 selects main upper input group
// - Source 00 counts prescaler, ignores soft bit
// - Source 01 counts each soft-bit write of 1
// - Source 10 rising, 11 falling edge counting
// - Aux source field behaves like main's
// - Main channel settings update together consistently
// - Each channel independently set to a capture mode
// - Mode 0100 rise to capture, fall shadow
// - Mode 0101 rising edge shifts shadow chain
// - Mode 0110 falling edge shifts shadow chain
// - Mode 0111 any edge shifts shadow chain
// - Four-bit mode field per channel
`include "tisdc_regs.vh"
module tisdc_top #(
    parameter TW = 16
) (
    clk_sys,
    rstn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    mainExtPins,
    auxExtPins,
    channelPin,
    channelAltOutIo,
    mainCount,
    auxCount
);
    input  wire            clk_sys;
    input  wire            rstn;
    input  wire            psel;
    input  wire            penable;
    input  wire            pwrite;
    input  wire [11:0]     paddr;
    input  wire [31:0]     pwdata;
    output reg  [31:0]     prdata;
    output reg             pready;
    output reg             pslverr;
    input  wire [7:0]      mainExtPins;
    input  wire [7:0]      auxExtPins;
    input  wire [2:0]      channelPin;
    output reg  [2:0]      channelAltOutIo;
    output reg  [TW-1:0]   mainCount;
    output reg  [TW-1:0]   auxCount;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, byte addresses
    // 0x000 input select: [1:0] aux select, [3:2] main source, [5:4] aux source,
    //       [6] main upper group, [7] aux upper group, [9:8] main select
    // 0x004 staged channel modes, four bits per channel
    // 0x008 software count strobes, [0] main, [1] aux; reads zero
    // 0x00c prescaler period minus one
    // 0x010 write [0]=1 takes over the staged modes; reads the active modes
    // 0x014 main counter, 0x018 aux counter, read only
    // 0x020 to 0x028 capture registers, 0x030 to 0x038 shadow registers
    // Unmapped offsets answer with pslverr and drop writes
    reg  [7:0]      inSel_ff;
    reg  [1:0]      mainSel_ff;
    reg  [11:0]     modeAct_ff;
    reg  [11:0]     modeShd_ff;
    reg  [15:0]     presc_ff;
    reg  [15:0]     prescCnt_ff;
    reg  [7:0]      mainS1_ff;
    reg  [7:0]      mainS2_ff;
    reg  [7:0]      auxS1_ff;
    reg  [7:0]      auxS2_ff;
    reg  [2:0]      chS1_ff;
    reg  [2:0]      chS2_ff;
    reg  [2:0]      chS3_ff;
    reg             mainIn_ff;
    reg             auxIn_ff;
    reg             mainSoft_ff;
    reg             auxSoft_ff;
    reg  [TW-1:0]   mainCnt_ff;
    reg  [TW-1:0]   auxCnt_ff;
    reg  [TW-1:0]   capReg_ff [0:2];
    reg  [TW-1:0]   shdReg_ff [0:2];
    // Writes land in the access phase; read data is prepared in the setup phase
    wire            wrEn = psel & penable & pwrite;
    wire            setupRd = psel & ~penable & ~pwrite;
    wire            prescTick = (prescCnt_ff == presc_ff);
    wire [2:0]      mainIdx = {inSel_ff[`TISDC_MAINEXT_BIT], mainSel_ff};
    wire [2:0]      auxIdx  = {inSel_ff[`TISDC_AUXEXT_BIT], inSel_ff[1:0]};
    wire            mainNow = mainS2_ff[mainIdx];
    wire            auxNow  = auxS2_ff[auxIdx];
    wire [1:0]      mainSrc = inSel_ff[3:2];
    wire [1:0]      auxSrc  = inSel_ff[5:4];
    reg             mainTick;
    reg             auxTick;
    reg  [31:0]     nxt_prdata;
    reg             nxt_err;

    ////////////////////////////////////////////////////////////////////////////
    // Count event selection; edge compare uses the value seen in the last cycle
    always @* begin
        case (mainSrc)
            `TISDC_SRC_PRESC: mainTick = prescTick;
            `TISDC_SRC_SOFT:  mainTick = mainSoft_ff;
            `TISDC_SRC_RISE:  mainTick = mainNow & ~mainIn_ff;
            default:          mainTick = ~mainNow & mainIn_ff;
        endcase
        case (auxSrc)
            `TISDC_SRC_PRESC: auxTick = prescTick;
            `TISDC_SRC_SOFT:  auxTick = auxSoft_ff;
            `TISDC_SRC_RISE:  auxTick = auxNow & ~auxIn_ff;
            default:          auxTick = ~auxNow & auxIn_ff;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for the candidate inputs, then one history stage
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mainS1_ff <= 8'h00;
            mainS2_ff <= 8'h00;
            auxS1_ff  <= 8'h00;
            auxS2_ff  <= 8'h00;
            mainIn_ff <= 1'b0;
            auxIn_ff  <= 1'b0;
        end else begin
            mainS1_ff <= mainExtPins;
            mainS2_ff <= mainS1_ff;
            auxS1_ff  <= auxExtPins;
            auxS2_ff  <= auxS1_ff;
            // Changing the select can give one false edge unless both inputs sit at one level
            mainIn_ff <= mainNow;
            auxIn_ff  <= auxNow;
        end
    end

    // Prescaler restarts on its own tick, so the period is the setting plus one
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            prescCnt_ff <= 16'h0000;
        else
            prescCnt_ff <= prescTick ? 16'h0000 : prescCnt_ff + 16'h0001;
    end

    // Output copies lag the counters by one cycle so that every output is a flop
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mainCnt_ff <= {TW{1'b0}};
            mainCount  <= {TW{1'b0}};
        end else begin
            if (mainTick)
                mainCnt_ff <= mainCnt_ff + {{(TW-1){1'b0}}, 1'b1};
            mainCount  <= mainCnt_ff;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            auxCnt_ff <= {TW{1'b0}};
            auxCount  <= {TW{1'b0}};
        end else begin
            if (auxTick)
                auxCnt_ff <= auxCnt_ff + {{(TW-1){1'b0}}, 1'b1};
            auxCount  <= auxCnt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; the channel modes are staged and taken over together so
    // that all three channels change in one cycle, never half-written
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            inSel_ff    <= `TISDC_RST_INSEL;
            mainSel_ff  <= `TISDC_RST_MAINSEL;
            modeAct_ff  <= `TISDC_RST_MODE;
            modeShd_ff  <= `TISDC_RST_MODE;
            presc_ff    <= `TISDC_RST_PRESC;
            mainSoft_ff <= 1'b0;
            auxSoft_ff  <= 1'b0;
        end else begin
            mainSoft_ff <= 1'b0;
            auxSoft_ff  <= 1'b0;
            if (wrEn) begin
                case (paddr)
                    `TISDC_OFS_INSEL: begin
                        inSel_ff   <= pwdata[7:0];
                        mainSel_ff <= pwdata[9:8];
                    end
                    `TISDC_OFS_MODE:  modeShd_ff <= pwdata[11:0];
                    `TISDC_OFS_SOFTCNT: begin
                        // One write of 1 gives exactly one count event
                        mainSoft_ff <= pwdata[0] & (mainSrc == `TISDC_SRC_SOFT);
                        auxSoft_ff  <= pwdata[1] & (auxSrc == `TISDC_SRC_SOFT);
                    end
                    `TISDC_OFS_PRESC: presc_ff <= pwdata[15:0];
                    `TISDC_OFS_SHADOWCTL: begin
                        if (pwdata[0])
                            modeAct_ff <= modeShd_ff;
                    end
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel capture; only the second stage feeds the history stage,
    // so edge detection never sees a possibly metastable first stage
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            chS1_ff <= 3'h0;
            chS2_ff <= 3'h0;
            chS3_ff <= 3'h0;
        end else begin
            chS1_ff <= channelPin;
            chS2_ff <= chS1_ff;
            chS3_ff <= chS2_ff;
        end
    end

    // Mode 0100 loads each register on its own edge; the shift modes move the
    // pair together, so the capture register always holds the older stamp
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gCh
            wire [3:0] mode = modeAct_ff[4*g+3:4*g];
            wire       rise = chS2_ff[g] & ~chS3_ff[g];
            wire       fall = ~chS2_ff[g] & chS3_ff[g];
            reg        shift;
            always @* begin
                case (mode)
                    `TISDC_MODE_RISE: shift = rise;
                    `TISDC_MODE_FALL: shift = fall;
                    `TISDC_MODE_ANY:  shift = rise | fall;
                    default:          shift = 1'b0;
                endcase
            end
            always @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    capReg_ff[g]       <= {TW{1'b0}};
                    shdReg_ff[g]       <= {TW{1'b0}};
                    channelAltOutIo[g] <= 1'b0;
                end else begin
                    // Alternate output pin claimed in shift modes, left to general I/O in mode 0100 and other modes
                    channelAltOutIo[g] <= (mode[3:2] == 2'b01) & (mode[1:0] != 2'b00);
                    if (mode == `TISDC_MODE_RF) begin
                        if (rise)
                            capReg_ff[g] <= mainCnt_ff;
                        if (fall)
                            shdReg_ff[g] <= mainCnt_ff;
                    end else if (shift) begin
                        capReg_ff[g] <= shdReg_ff[g];
                        shdReg_ff[g] <= mainCnt_ff;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // APB read path; zero wait states, unmapped reads return zero with error
    always @* begin
        nxt_prdata = 32'h0000_0000;
        nxt_err    = 1'b0;
        case (paddr)
            `TISDC_OFS_INSEL:     nxt_prdata = {22'h0, mainSel_ff, inSel_ff};
            `TISDC_OFS_MODE:      nxt_prdata = {20'h0, modeShd_ff};
            `TISDC_OFS_SOFTCNT:   nxt_prdata = 32'h0000_0000;
            `TISDC_OFS_PRESC:     nxt_prdata = {16'h0, presc_ff};
            `TISDC_OFS_SHADOWCTL: nxt_prdata = {20'h0, modeAct_ff};
            `TISDC_OFS_MAINCNT:   nxt_prdata = {{(32-TW){1'b0}}, mainCnt_ff};
            `TISDC_OFS_AUXCNT:    nxt_prdata = {{(32-TW){1'b0}}, auxCnt_ff};
            `TISDC_OFS_CAP0:      nxt_prdata = {{(32-TW){1'b0}}, capReg_ff[0]};
            `TISDC_OFS_CAP1:      nxt_prdata = {{(32-TW){1'b0}}, capReg_ff[1]};
            `TISDC_OFS_CAP2:      nxt_prdata = {{(32-TW){1'b0}}, capReg_ff[2]};
            `TISDC_OFS_SHD0:      nxt_prdata = {{(32-TW){1'b0}}, shdReg_ff[0]};
            `TISDC_OFS_SHD1:      nxt_prdata = {{(32-TW){1'b0}}, shdReg_ff[1]};
            `TISDC_OFS_SHD2:      nxt_prdata = {{(32-TW){1'b0}}, shdReg_ff[2]};
            default:              nxt_err    = 1'b1;
        endcase
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Answer registered so the access phase lasts exactly one cycle
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & nxt_err;
            // Data is zero outside the answer cycle, so a stale word never lingers
            prdata  <= setupRd ? nxt_prdata : 32'h0000_0000;
        end
    end
endmodule // tisdc_top

// File: core/tisdc_regs.vh
// Register offsets, field positions, reset values and mode codes of the timer input select and capture block
`ifndef TISDC_REGS_VH
`define TISDC_REGS_VH
`define TISDC_OFS_INSEL      12'h000
`define TISDC_OFS_MODE       12'h004
`define TISDC_OFS_SOFTCNT    12'h008
`define TISDC_OFS_PRESC      12'h00c
`define TISDC_OFS_SHADOWCTL  12'h010
`define TISDC_OFS_MAINCNT    12'h014
`define TISDC_OFS_AUXCNT     12'h018
`define TISDC_OFS_CAP0       12'h020
`define TISDC_OFS_CAP1       12'h024
`define TISDC_OFS_CAP2       12'h028
`define TISDC_OFS_SHD0       12'h030
`define TISDC_OFS_SHD1       12'h034
`define TISDC_OFS_SHD2       12'h038
`define TISDC_RST_MAINSEL    2'h0
`define TISDC_RST_INSEL      8'h00
`define TISDC_RST_MODE       12'h000
`define TISDC_RST_PRESC      16'h0000
`define TISDC_AUXSEL_LSB     0
`define TISDC_MAINSRC_LSB    2
`define TISDC_AUXSRC_LSB     4
`define TISDC_MAINEXT_BIT    6
`define TISDC_AUXEXT_BIT     7
`define TISDC_MAINSEL_LSB    8
`define TISDC_SRC_PRESC      2'h0
`define TISDC_SRC_SOFT       2'h1
`define TISDC_SRC_RISE       2'h2
`define TISDC_SRC_FALL       2'h3
`define TISDC_MODE_RF        4'h4
`define TISDC_MODE_RISE      4'h5
`define TISDC_MODE_FALL      4'h6
`define TISDC_MODE_ANY       4'h7
`endif

// File: verif/tisdc_pins.sv
// Pin model driving the count and capture inputs
module tisdc_pins (
    input  logic        clk_sys,
    input  logic [18:0] req,
    output logic [7:0]  mainExtPins = 8'h0,
    output logic [7:0]  auxExtPins = 8'h0,
    output logic [2:0]  channelPin = 3'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // Levels move only after an edge, so every pulse lasts whole cycles at the synchronisers
    always @(posedge clk_sys) begin
        {channelPin, auxExtPins, mainExtPins} <= req;
    end
endmodule // tisdc_pins

// File: verif/tisdc_monitor.sv
// Port checker for the timer input select and capture block
module tisdc_monitor #(parameter TW = 16) (
    input logic          clk_sys,
    input logic          rstn,
    input logic          psel,
    input logic          penable,
    input logic [11:0]   paddr,
    input logic [31:0]   prdata,
    input logic          pready,
    input logic          pslverr,
    input logic [2:0]    channelAltOutIo,
    input logic [TW-1:0] mainCount,
    input logic [TW-1:0] auxCount
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence setupPh; psel && !penable; endsequence
    sequence accessPh; psel && penable; endsequence
    sequence noLoad; !(psel && paddr == 12'h010); endsequence
    ////////////////////
    setup_ready_a: assert property (setupPh ##1 accessPh |-> pready) else $error("no pready");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
    err_with_ready_a: assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
    idle_data_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray prdata");
    unmapped_err_a: assert property (pready && paddr >= 12'h040 |-> pslverr) else $error("no pslverr");
    main_step_one_a: assert property ($changed(mainCount) |-> mainCount == $past(mainCount) + 1'b1)
        else $error("main count jump");
    aux_step_one_a: assert property ($changed(auxCount) |-> auxCount == $past(auxCount) + 1'b1)
        else $error("aux count jump");
    mode_on_load_a: assert property (noLoad [*3] |=> $stable(channelAltOutIo))
        else $error("mode moved unloaded");
endmodule // tisdc_monitor
bind tisdc_top tisdc_monitor #(.TW(TW)) monitor (.*);

// File: verif/tisdc_bench.sv
// Self-checking bench for the timer input select and capture block
module tisdc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, ins, err;
    logic [18:0] pinReq = 19'h0;
    logic [7:0]  mainExtPins, auxExtPins, r;
    logic [2:0]  channelPin, channelAltOutIo, s;
    logic [15:0] mainCount, auxCount, base, tm, cap = 16'h0, shd = 16'h0;
    int          n_mismatch = 0, tests_run = 0;
    always #4 clk_sys = ~clk_sys;
    tisdc_top #(.TW(16)) DUT (.*);
    tisdc_pins pins (.clk_sys(clk_sys), .req(pinReq), .mainExtPins(mainExtPins), .auxExtPins(auxExtPins),
        .channelPin(channelPin));
    ////////////////////
    task automatic close_out;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Ends with an idle cycle so a following call never drives psel twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge clk_sys);
        if (i == 16) begin
            chk("pready", 32'h1, 32'h0);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clk_sys);
    endtask
    function automatic void capModel(input int m, input logic rise);
        if (m == 4 && rise) cap = tm;
        else if (m == 4) shd = tm;
        else if (m == 7 || (m == 5 && rise) || (m == 6 && !rise)) begin
            cap = shd;
            shd = tm;
        end
    endfunction
    ////////////////////
    initial begin
        void'($urandom(31));
        tick(5);
        rstn <= 1'b1;
        tick(1);
        apb(1'b0, 12'h000, 32'h0);
        chk("insel", 32'h0, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("mode", 32'h0, rd);
        apb(1'b1, 12'h01c, 32'h5);
        chk("unmapped", 32'h1, err);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped rd err", 32'h1, err);
        chk("unmapped rd data", 32'h0, rd);
        // Slow prescaler keeps the timer still wherever it is not the chosen source
        apb(1'b1, 12'h00c, 32'hffff);
        for (int k = 0; k < 4; k++) begin
            s = $urandom;
            ins = k[1] ? {24'h0, s[2], 2'b01, k[0], 2'b00, s[1:0]} : {22'h0, s[1:0], 1'b0, s[2], 3'b001, k[0], 2'b00};
            apb(1'b1, 12'h000, ins);
            apb(1'b0, 12'h000, 32'h0);
            chk("insel rw", ins, rd);
            base = k[1] ? auxCount : mainCount;
            for (int h = 1; h >= 0; h--) begin
                r = $urandom;
                r[s] = h[0];
                pinReq <= k[1] ? {3'h0, r, 8'h0} : {11'h0, r};
                tick(8);
                chk("edge count", 16'(base + (h ? !k[0] : 1)), k[1] ? auxCount : mainCount);
            end
            pinReq <= 19'h0;
            tick(8);
        end
        apb(1'b1, 12'h000, 32'h14);
        base = mainCount;
        tm = auxCount;
        repeat (3) apb(1'b1, 12'h008, 32'h3);
        tick(4);
        chk("main soft", 16'(base + 3), mainCount);
        chk("aux soft", 16'(tm + 3), auxCount);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h008, 32'h3);
        tick(4);
        chk("soft ignored", 16'(base + 3), mainCount);
        apb(1'b1, 12'h000, 32'h4);
        tm = base + 3;
        for (int m = 4; m < 8; m++) begin
            apb(1'b1, 12'h004, m);
            tick(3);
            chk("staged mode", {31'h0, m > 5}, channelAltOutIo);
            apb(1'b1, 12'h010, 32'h1);
            tick(3);
            chk("alt out", {31'h0, m > 4}, channelAltOutIo);
            for (int h = 1; h >= 0; h--) begin
                apb(1'b1, 12'h008, 32'h1);
                tm++;
                pinReq <= {2'b0, h[0], 16'h0};
                tick(8);
                capModel(m, h[0]);
                apb(1'b0, 12'h020, 32'h0);
                chk("capture", cap, rd);
                apb(1'b0, 12'h030, 32'h0);
                chk("shadow", shd, rd);
            end
        end
        close_out();
    end
endmodule // tisdc_bench
